// ### bcr_pkg.sv
// Constants and types for the bridge configuration register group
package bcr_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_FRAG_CTRL   = 8'h68;
	localparam logic [7:0] OFS_SUBSYS      = 8'h6c;
	localparam logic [7:0] OFS_EE_CTRL     = 8'h70;
	localparam logic [7:0] OFS_HOTSWAP     = 8'h74;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int FRAG_LSB       = 30;
	localparam int EE_INIT_BIT    = 0;
	localparam int EE_CMD_BIT     = 1;
	localparam int EE_ERR_BIT     = 2;
	localparam int EE_DONE_BIT    = 3;
	localparam int EE_CLKSEL_LSB  = 4;
	localparam int EE_ALDIS_BIT   = 6;
	localparam int EE_FAST_BIT    = 7;
	localparam int EE_BUSY_BIT    = 8;
	localparam int EE_WADDR_LSB   = 9;
	localparam int EE_DATA_LSB    = 16;
	localparam int HS_NEXT_LSB    = 8;
	localparam int HS_HIDE_BIT    = 16;
	localparam int HS_MASK_BIT    = 17;
	localparam int HS_PEND_BIT    = 18;
	localparam int HS_LED_BIT     = 19;
	localparam int HS_PI_LSB      = 20;
	localparam int HS_EXT_BIT     = 22;
	localparam int HS_INS_BIT     = 23;

	// ----------------------------------------------------------------
	// Values and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0]  HS_CAP_ID_ON   = 8'h06;
	localparam logic [7:0]  HS_CAP_ID_OFF  = 8'h00;
	localparam logic [7:0]  HS_NEXT_PTR    = 8'h00;
	localparam logic [1:0]  HS_PI_LEVEL    = 2'h1;
	localparam logic        INS_RESET      = 1'b1;
	localparam logic [15:0] SUBSYS_RESET   = 16'h0000;
	localparam logic [7:0]  FRAG_BYTES_32  = 8'h20;
	localparam logic [7:0]  FRAG_BYTES_64  = 8'h40;
	localparam logic [7:0]  FRAG_BYTES_128 = 8'h80;

	// ----------------------------------------------------------------
	// Serial clock divisors and autoload layout
	// ----------------------------------------------------------------
	localparam logic [12:0] DIV_SEL0       = 13'h1000;
	localparam logic [12:0] DIV_SEL1       = 13'h0800;
	localparam logic [12:0] DIV_SEL2       = 13'h0400;
	localparam logic [12:0] DIV_SEL3       = 13'h0080;
	localparam int          FAST_SHIFT     = 5;
	localparam logic [6:0]  AL_VENDOR_WORD = 7'h00;
	localparam logic [6:0]  AL_SUBSYS_WORD = 7'h01;

	typedef enum logic [3:0] {
		ST_BOOT  = 4'b0001,
		ST_IDLE  = 4'b0010,
		ST_ALOAD = 4'b0100,
		ST_SWCYC = 4'b1000
	} bcr_state_type;

endpackage

// ### bcr_regs.sv
// Bridge configuration registers: fragment, subsystem, EEPROM, hot swap
//
// Overview of operation
// - Fragment field 00 gives 32 bytes, 01 gives 64, upper bit gives 128
// - Subsystem vendor identifier is read-only, low half, resets to zero
// - Subsystem identifier is read-only, upper half, resets to zero
// - Initiate 0 to 1 starts one EEPROM access, read or write by command
// - Initiate bit clears itself when the EEPROM operation finishes
// - Error flag sets when an EEPROM acknowledge is missing
// - Completion flag set once autoload succeeds, else reads zero
// - Serial clock is core clock divided by 4096, 2048, 1024 or 128
// - Autoload runs after every reset; its control bit resets 0 and is read only at boot, so it is never skipped
// - Fast-autoload bit makes autoload run 32 times faster
// - Busy flag stays high while autoload is in progress
// - Seven-bit word address field for software EEPROM cycles, reset 0
// - Sixteen-bit data field holds the word to write, or the word read back
// - Hot-swap capability identifier reads 06h with strap high, else 00h
// - Next-capability pointer reads 00h, ending the capability list
// - Writing 1 to the hiding arm bit arms device hiding; resets zero
// - Mask bit set masks the enumeration notification; resets zero
// - Pending bit reads 1 when hiding armed or either flag set
// - Hot-swap LED follows the LED control bit; resets zero
// - Programming interface field reads 01
// - Extraction flag sets on extraction, write 1 clears, resets zero
// - Insertion flag sets on insertion, clears on writing 1, resets one
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module bcr_regs
	import bcr_pkg::*;
(
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst,
	// Register port
	input  wire logic [7:0]  regAddr,
	input  wire logic [31:0] regWrData,
	input  wire logic        regWrStb,
	input  wire logic        regRdStb,
	output logic      [31:0] regRdData,
	// EEPROM word engine
	output logic             eeReq,
	output logic             eeWrite,
	output logic      [6:0]  eeAddr,
	output logic      [15:0] eeWrData,
	output logic             eeSclk,
	input  wire logic        eeDone,
	input  wire logic        eeAckOk,
	input  wire logic [15:0] eeRdData,
	// Hot swap
	input  wire logic        hotswapStrapEnable,
	input  wire logic        insertEvent,
	input  wire logic        extractEvent,
	output logic             enumNotify_n,
	output logic             hotswapLed,
	output logic             deviceHidingArm,
	// Forwarding
	output logic      [7:0]  fragBytes
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		bcr_state_type state;
		logic          alIdx;
		logic [1:0]    fragCtl;
		logic [7:0]    fragBytes;
		logic [15:0]   ssVendor;
		logic [15:0]   ssId;
		logic          initiate;
		logic          cmdWrite;
		logic          eeErr;
		logic          alComplete;
		logic [1:0]    clkSel;
		logic          alDisable;
		logic          alFast;
		logic          alBusy;
		logic [6:0]    wordAddr;
		logic [15:0]   eeData;
		logic          capOn;
		logic          hideArm;
		logic          enumMask;
		logic          ledOn;
		logic          extFlag;
		logic          insFlag;
		logic          enumN;
		logic [11:0]   divCnt;
		logic          sclk;
		logic          eeReq;
		logic          eeWrite;
		logic [6:0]    eeAddr;
		logic [15:0]   eeWrData;
		logic [31:0]   rdData;
	} bcr_regs_type;

	bcr_regs_type s_reg;
	bcr_regs_type s_next;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Half period of the serial clock in core cycles
	function automatic logic [11:0] halfPeriod(input logic [1:0] sel,
		input logic fast);
		logic [12:0] div;
		div = DIV_SEL0;
		case (sel)
			2'h0: div = DIV_SEL0;
			2'h1: div = DIV_SEL1;
			2'h2: div = DIV_SEL2;
			default: div = DIV_SEL3;
		endcase
		if (fast)
		begin
			div = div >> FAST_SHIFT;
		end
		return div[12:1];
	endfunction

	function automatic logic [7:0] fragSize(input logic [1:0] ctl);
		logic [7:0] b;
		b = FRAG_BYTES_32;
		if (ctl[1])
		begin
			b = FRAG_BYTES_128;
		end
		else if (ctl[0])
		begin
			b = FRAG_BYTES_64;
		end
		return b;
	endfunction

	function automatic logic [31:0] readMux(input bcr_regs_type r,
		input logic [7:0] a);
		logic [31:0] d;
		d = 32'h0000_0000;
		case (a)
			OFS_FRAG_CTRL:
			begin
				d[FRAG_LSB +: 2] = r.fragCtl;
			end
			OFS_SUBSYS:
			begin
				d = {r.ssId, r.ssVendor};
			end
			OFS_EE_CTRL:
			begin
				d[EE_INIT_BIT]        = r.initiate;
				d[EE_CMD_BIT]         = r.cmdWrite;
				d[EE_ERR_BIT]         = r.eeErr;
				d[EE_DONE_BIT]        = r.alComplete;
				d[EE_CLKSEL_LSB +: 2] = r.clkSel;
				d[EE_ALDIS_BIT]       = r.alDisable;
				d[EE_FAST_BIT]        = r.alFast;
				d[EE_BUSY_BIT]        = r.alBusy;
				d[EE_WADDR_LSB +: 7]  = r.wordAddr;
				d[EE_DATA_LSB +: 16]  = r.eeData;
			end
			OFS_HOTSWAP:
			begin
				d[7:0] = r.capOn ? HS_CAP_ID_ON : HS_CAP_ID_OFF;
				d[HS_NEXT_LSB +: 8] = HS_NEXT_PTR;
				d[HS_HIDE_BIT]      = r.hideArm;
				d[HS_MASK_BIT]      = r.enumMask;
				d[HS_PEND_BIT]      = r.hideArm | r.insFlag
					| r.extFlag;
				d[HS_LED_BIT]       = r.ledOn;
				d[HS_PI_LSB +: 2]   = HS_PI_LEVEL;
				d[HS_EXT_BIT]       = r.extFlag;
				d[HS_INS_BIT]       = r.insFlag;
			end
			default:
			begin
				d = 32'h0000_0000;
			end
		endcase
		return d;
	endfunction

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		logic wrFrag;
		logic wrEe;
		logic wrHs;
		logic startSw;
		wrFrag  = regWrStb && (regAddr == OFS_FRAG_CTRL);
		wrEe    = regWrStb && (regAddr == OFS_EE_CTRL);
		wrHs    = regWrStb && (regAddr == OFS_HOTSWAP);
		startSw = 1'b0;
		s_next  = s_reg;

		// Register reads, data valid in the next cycle only
		s_next.rdData = regRdStb ? readMux(s_reg, regAddr) : 32'h0000_0000;

		// Fragment control
		if (wrFrag)
		begin
			s_next.fragCtl = regWrData[FRAG_LSB +: 2];
		end
		s_next.fragBytes = fragSize(s_reg.fragCtl);

		// EEPROM control fields
		if (wrEe)
		begin
			s_next.cmdWrite  = regWrData[EE_CMD_BIT];
			s_next.clkSel    = regWrData[EE_CLKSEL_LSB +: 2];
			s_next.alDisable = regWrData[EE_ALDIS_BIT];
			s_next.alFast    = regWrData[EE_FAST_BIT];
			s_next.wordAddr  = regWrData[EE_WADDR_LSB +: 7];
			s_next.eeData    = regWrData[EE_DATA_LSB +: 16];
			startSw = regWrData[EE_INIT_BIT] && !s_reg.initiate;
		end

		// Serial clock divider, free running while a cycle is in flight
		if (s_reg.eeReq)
		begin
			if (s_reg.divCnt == 12'h000)
			begin
				s_next.divCnt = halfPeriod(s_reg.clkSel,
					s_reg.alBusy && s_reg.alFast) - 12'h001;
				s_next.sclk = !s_reg.sclk;
			end
			else
			begin
				s_next.divCnt = s_reg.divCnt - 12'h001;
			end
		end
		else
		begin
			s_next.divCnt = 12'h000;
			s_next.sclk   = 1'b0;
		end

		// EEPROM sequencing
		case (s_reg.state)
			ST_BOOT:
			begin
				if (!s_reg.alDisable)
				begin
					s_next.state      = ST_ALOAD;
					s_next.alBusy     = 1'b1;
					s_next.alIdx      = 1'b0;
					s_next.eeErr      = 1'b0;
					s_next.alComplete = 1'b0;
					s_next.eeReq      = 1'b1;
					s_next.eeWrite    = 1'b0;
					s_next.eeAddr     = AL_VENDOR_WORD;
				end
				else
				begin
					s_next.state = ST_IDLE;
				end
			end
			ST_IDLE:
			begin
				if (startSw)
				begin
					s_next.state    = ST_SWCYC;
					s_next.initiate = 1'b1;
					s_next.eeErr    = 1'b0;
					s_next.eeReq    = 1'b1;
					s_next.eeWrite  = regWrData[EE_CMD_BIT];
					s_next.eeAddr   = regWrData[EE_WADDR_LSB +: 7];
					s_next.eeWrData = regWrData[EE_DATA_LSB +: 16];
				end
			end
			ST_ALOAD:
			begin
				if (eeDone)
				begin
					if (!eeAckOk)
					begin
						s_next.eeErr = 1'b1;
					end
					if (!s_reg.alIdx)
					begin
						s_next.ssVendor = eeRdData;
						s_next.alIdx    = 1'b1;
						s_next.eeAddr   = AL_SUBSYS_WORD;
					end
					else
					begin
						s_next.ssId       = eeRdData;
						s_next.eeReq      = 1'b0;
						s_next.alBusy     = 1'b0;
						s_next.alComplete = eeAckOk && !s_reg.eeErr;
						s_next.state      = ST_IDLE;
					end
				end
			end
			ST_SWCYC:
			begin
				if (eeDone)
				begin
					if (!eeAckOk)
					begin
						s_next.eeErr = 1'b1;
					end
					if (!s_reg.eeWrite)
					begin
						s_next.eeData = eeRdData;
					end
					s_next.eeReq    = 1'b0;
					s_next.initiate = 1'b0;
					s_next.state    = ST_IDLE;
				end
			end
			default:
			begin
				s_next.state = ST_IDLE;
				s_next.eeReq = 1'b0;
			end
		endcase

		// Hot swap control; hardware set wins over software clear
		if (wrHs)
		begin
			s_next.hideArm  = regWrData[HS_HIDE_BIT];
			s_next.enumMask = regWrData[HS_MASK_BIT];
			s_next.ledOn    = regWrData[HS_LED_BIT];
			if (regWrData[HS_EXT_BIT])
			begin
				s_next.extFlag = 1'b0;
			end
			if (regWrData[HS_INS_BIT])
			begin
				s_next.insFlag = 1'b0;
			end
		end
		if (extractEvent)
		begin
			s_next.extFlag = 1'b1;
		end
		if (insertEvent)
		begin
			s_next.insFlag = 1'b1;
		end
		s_next.enumN = !((s_next.insFlag || s_next.extFlag)
			&& !s_next.enumMask);
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			s_reg            <= '0;
			s_reg.state      <= ST_BOOT;
			s_reg.fragBytes  <= FRAG_BYTES_32;
			s_reg.ssVendor   <= SUBSYS_RESET;
			s_reg.ssId       <= SUBSYS_RESET;
			s_reg.insFlag    <= INS_RESET;
			s_reg.enumN      <= 1'b1;
			s_reg.capOn      <= 1'b0;
		end
		else
		begin
			s_reg       <= s_next;
			// Strap caught while running, after release
			s_reg.capOn <= hotswapStrapEnable;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign regRdData       = s_reg.rdData;
	assign eeReq           = s_reg.eeReq;
	assign eeWrite         = s_reg.eeWrite;
	assign eeAddr          = s_reg.eeAddr;
	assign eeWrData        = s_reg.eeWrData;
	assign eeSclk          = s_reg.sclk;
	assign enumNotify_n    = s_reg.enumN;
	assign hotswapLed      = s_reg.ledOn;
	assign deviceHidingArm = s_reg.hideArm;
	assign fragBytes       = s_reg.fragBytes;

endmodule

`default_nettype wire

// ### bcr_regs_checker.sv
// Assertion checker for the bridge configuration register group
`timescale 1ns/1ps
`default_nettype none
module bcr_regs_checker
	import bcr_pkg::*;
(
	// Clock and reset
	input wire logic        core_clk,
	input wire logic        rst,
	// Register port
	input wire logic [7:0]  regAddr,
	input wire logic [31:0] regWrData,
	input wire logic        regWrStb,
	input wire logic        regRdStb,
	input wire logic [31:0] regRdData,
	// EEPROM engine and outputs
	input wire logic        eeReq,
	input wire logic        eeWrite,
	input wire logic [6:0]  eeAddr,
	input wire logic [15:0] eeWrData,
	input wire logic        eeSclk,
	input wire logic        eeDone,
	input wire logic        enumNotify_n,
	input wire logic        hotswapLed,
	input wire logic [7:0]  fragBytes
);
	// ------------
	// Serial clock half-period count
	// ------------
	logic [11:0] gap_reg;
	logic        seen_reg;
	logic        last_reg;
	logic        hsRd;
	assign hsRd = regRdStb && regAddr == OFS_HOTSWAP;
	always_ff @(posedge core_clk)
	begin
		last_reg <= eeSclk;
		if (rst || !eeReq || eeDone)
		begin
			gap_reg  <= 12'h0;
			seen_reg <= 1'b0;
		end
		else if (eeSclk != last_reg)
		begin
			gap_reg  <= 12'h1;
			seen_reg <= 1'b1;
		end
		else
			gap_reg <= gap_reg + 12'h1;
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	AST_FRAG: assert property (
		regWrStb && regAddr == OFS_FRAG_CTRL && regWrData[31]
		|-> ##[1:2] fragBytes == FRAG_BYTES_128)
		else $error("fragment size not 128");
	AST_LED: assert property (
		regWrStb && regAddr == OFS_HOTSWAP
		|=> hotswapLed == $past(regWrData[HS_LED_BIT]))
		else $error("led mismatch");
	AST_HSRD: assert property (
		hsRd |=> regRdData[21:20] == HS_PI_LEVEL
		&& regRdData[15:8] == HS_NEXT_PTR
		&& regRdData[18] == |{regRdData[23:22], regRdData[16]})
		else $error("hot swap read mismatch");
	AST_ENUM: assert property (
		hsRd |=> enumNotify_n == !(|regRdData[23:22] && !regRdData[17]))
		else $error("notify mismatch");
	AST_START: assert property (
		regWrStb && regAddr == OFS_EE_CTRL && regWrData[0] && !eeReq
		|=> eeReq && eeWrite == $past(regWrData[1])
		&& eeAddr == $past(regWrData[15:9]))
		else $error("start mismatch");
	AST_HOLD: assert property (
		eeReq && !eeDone |=> eeReq && $stable(eeAddr)
		&& $stable(eeWrData) && $stable(eeWrite))
		else $error("request not held");
	AST_END: assert property (
		eeReq && eeDone && eeAddr != 7'h0 |=> !eeReq)
		else $error("request not ended");
	AST_DIV: assert property (
		eeReq && seen_reg && eeSclk != last_reg
		|-> gap_reg inside {12'h800, 12'h400, 12'h200, 12'h040,
		12'h020, 12'h010, 12'h002})
		else $error("serial clock period wrong");
endmodule
bind bcr_regs bcr_regs_checker chk_i (.core_clk, .rst, .regAddr,
	.regWrData, .regWrStb, .regRdStb, .regRdData, .eeReq, .eeWrite,
	.eeAddr, .eeWrData, .eeSclk, .eeDone, .enumNotify_n, .hotswapLed,
	.fragBytes);
`default_nettype wire

// ### bcr_ee_model.sv
// Behavioural serial EEPROM behind the word engine
`timescale 1ns/1ps
`default_nettype none
module bcr_ee_model
	import bcr_pkg::*;
#(
	parameter logic [15:0] WORD0 = 16'h0000,
	parameter logic [15:0] WORD1 = 16'h0000
)
(
	// Clock and reset
	input wire logic        core_clk,
	input wire logic        rst,
	// Word engine side
	input wire logic        eeReq,
	input wire logic        eeWrite,
	input wire logic [6:0]  eeAddr,
	input wire logic [15:0] eeWrData,
	input wire logic        eeSclk,
	output logic            eeDone,
	output logic            eeAckOk,
	output logic     [15:0] eeRdData,
	// Test controls
	input wire logic [3:0]  slowEdges,
	input wire logic        nack
);
	logic [15:0] mem [0:127];
	logic [15:0] word_reg;
	logic [3:0]  edge_reg;
	logic        last_reg;
	// Data line shows a changed word outside the answer cycle
	assign eeRdData = eeDone ? word_reg : ~word_reg;
	always_ff @(posedge core_clk)
	begin
		last_reg <= eeSclk;
		eeDone <= 1'b0;
		if (rst)
		begin
			edge_reg <= 4'h0;
			eeAckOk <= 1'b1;
			word_reg <= 16'h0;
			mem[0] <= WORD0;
			mem[1] <= WORD1;
		end
		else if (eeReq && !eeDone)
		begin
			if (eeSclk && !last_reg)
				edge_reg <= edge_reg + 4'h1;
			if (edge_reg == slowEdges)
			begin
				eeDone <= 1'b1;
				eeAckOk <= !nack;
				edge_reg <= 4'h0;
				word_reg <= mem[eeAddr];
				if (eeWrite && !nack)
					mem[eeAddr] <= eeWrData;
			end
		end
	end
endmodule
`default_nettype wire

// ### test_bcr_regs.sv
// Self-checking testbench for the bridge configuration register group
`timescale 1ns/1ps
`default_nettype none
module test_bcr_regs
	import bcr_pkg::*;
;
	localparam logic [15:0] VEND = 16'h1c2d;
	localparam logic [15:0] SUBS = 16'h3e4f;
	localparam logic [7:0]  FB [4] = '{FRAG_BYTES_32, FRAG_BYTES_64,
		FRAG_BYTES_128, FRAG_BYTES_128};
	logic        core_clk, rst, regWrStb, regRdStb, eeReq, eeWrite, eeSclk;
	logic        eeDone, eeAckOk, hotswapStrapEnable, insertEvent, nack;
	logic        extractEvent, enumNotify_n, hotswapLed, deviceHidingArm;
	logic [31:0] regWrData, regRdData, d;
	logic [15:0] eeWrData, eeRdData;
	logic [7:0]  regAddr, fragBytes;
	logic [6:0]  eeAddr;
	logic [3:0]  slowEdges;
	int          miscompares, checks;

	bcr_regs DUT (.core_clk, .rst, .regAddr, .regWrData, .regWrStb,
		.regRdStb, .regRdData, .eeReq, .eeWrite, .eeAddr, .eeWrData,
		.eeSclk, .eeDone, .eeAckOk, .eeRdData, .hotswapStrapEnable,
		.insertEvent, .extractEvent, .enumNotify_n, .hotswapLed,
		.deviceHidingArm, .fragBytes);
	bcr_ee_model #(.WORD0(VEND), .WORD1(SUBS)) eeprom (.core_clk, .rst,
		.eeReq, .eeWrite, .eeAddr, .eeWrData, .eeSclk, .eeDone,
		.eeAckOk, .eeRdData, .slowEdges, .nack);

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		regAddr <= a;
		regWrData <= v;
		regWrStb <= 1'b1;
		@(posedge core_clk);
		regWrStb <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		regAddr <= a;
		regRdStb <= 1'b1;
		@(posedge core_clk);
		regRdStb <= 1'b0;
		@(negedge core_clk);
		v = regRdData;
		@(posedge core_clk);
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e)
		begin
			miscompares++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic idle();
		logic [31:0] v;
		v = 32'h1;
		for (int k = 0; k < 6000 && (v & 32'h101) != 32'h0; k++)
			rd(OFS_EE_CTRL, v);
		chk(v & 32'h101, 32'h0);
	endtask
	task automatic pulse(input logic [1:0] ev);
		{insertEvent, extractEvent} <= ev;
		@(posedge core_clk);
		{insertEvent, extractEvent} <= 2'h0;
		@(posedge core_clk);
	endtask
	task automatic tally_and_finish();
		if (miscompares == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial
	begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	// Hang guard, well beyond the slowest autoload
	initial
	begin
		#150000;
		miscompares++;
		tally_and_finish();
	end
	initial
	begin
		{rst, regWrStb, regRdStb, insertEvent, extractEvent, nack} = 6'h20;
		{regAddr, regWrData} = 40'h0;
		hotswapStrapEnable = 1'b1;
		slowEdges = 4'h1;
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		repeat (3) @(posedge core_clk);
		rd(OFS_SUBSYS, d);
		chk(d, 32'h0);
		rd(OFS_EE_CTRL, d);
		chk(d, 32'h100);
		rd(OFS_HOTSWAP, d);
		chk(d, 32'h0094_0006);
		chk({31'h0, enumNotify_n}, 32'h0);
		idle();
		rd(OFS_EE_CTRL, d);
		chk(d & 32'h10f, 32'h8);
		wr(OFS_SUBSYS, 32'hffff_ffff);
		rd(OFS_SUBSYS, d);
		chk(d, {SUBS, VEND});
		for (int i = 0; i < 4; i++)
		begin
			wr(OFS_FRAG_CTRL, {i[1:0], 30'h0});
			rd(OFS_FRAG_CTRL, d);
			chk(d, {i[1:0], 30'h0});
			chk({24'h0, fragBytes}, {24'h0, FB[i]});
		end
		wr(OFS_EE_CTRL, 32'ha5c3_0a33);
		@(negedge core_clk);
		chk({7'h0, eeReq, eeWrite, eeAddr, eeWrData},
			32'h1_85a5c3);
		@(posedge core_clk);
		idle();
		wr(OFS_EE_CTRL, 32'h0000_0a21);
		idle();
		rd(OFS_EE_CTRL, d);
		chk(d & 32'hffff_0007, 32'ha5c3_0000);
		slowEdges <= 4'h3;
		// Divisor selects 11, 10, 01 in turn; middle pass is refused
		for (int n = 2; n >= 0; n--)
		begin
			nack <= n[0];
			wr(OFS_EE_CTRL, {24'h00000c, 2'h0, 2'(n + 1), 4'h1});
			idle();
			rd(OFS_EE_CTRL, d);
			chk(d & 32'h5, {29'h0, n[0], 2'h0});
		end
		wr(OFS_HOTSWAP, 32'h000b_0000);
		chk({29'h0, hotswapLed, deviceHidingArm, enumNotify_n},
			32'h7);
		wr(OFS_HOTSWAP, 32'h008b_0000);
		rd(OFS_HOTSWAP, d);
		chk(d, 32'h001f_0006);
		wr(OFS_HOTSWAP, 32'h0);
		rd(OFS_HOTSWAP, d);
		chk(d, 32'h0010_0006);
		chk({29'h0, hotswapLed, deviceHidingArm, enumNotify_n},
			32'h1);
		pulse(2'h1);
		rd(OFS_HOTSWAP, d);
		chk(d, 32'h0054_0006);
		chk({31'h0, enumNotify_n}, 32'h0);
		wr(OFS_HOTSWAP, 32'h0040_0000);
		chk({31'h0, enumNotify_n}, 32'h1);
		pulse(2'h2);
		rd(OFS_HOTSWAP, d);
		chk(d, 32'h0094_0006);
		hotswapStrapEnable <= 1'b0;
		repeat (2) @(posedge core_clk);
		rd(OFS_HOTSWAP, d);
		chk(d & 32'hff, 32'h0);
		rd(8'h7c, d);
		chk(d, 32'h0);
		tally_and_finish();
	end
endmodule
`default_nettype wire
